// file: hw/tcwr_defs.vh
// Purpose: Constants for the tuner control write register bank
// Assumes: Byte numbers follow the device's write byte order 2 to 13
// Notes:   Definitions only
`ifndef TCWR_DEFS_VH
`define TCWR_DEFS_VH
`define TCWR_RST_B2      8'h00
`define TCWR_RST_B3      8'h00
`define TCWR_RST_B4      8'h80
`define TCWR_RST_B5      8'h00
`define TCWR_RST_B6      8'hc0
`define TCWR_RST_B7      8'h20
`define TCWR_RST_B8      8'hdb
`define TCWR_RST_B9      8'h30
`define TCWR_RST_B10     8'he1
`define TCWR_RST_B11     8'h75
`define TCWR_RST_B12     8'hf0
`define TCWR_RST_B13     8'h28
`define TCWR_FIRST_BYTE  4'h2
`define TCWR_LAST_BYTE   4'hd
`define TCWR_B4_RFG      5
`define TCWR_B4_PRE_HI   4
`define TCWR_B4_PRE_LO   3
`define TCWR_B4_POST_HI  2
`define TCWR_B4_POST_LO  1
`define TCWR_B4_BYP      0
`define TCWR_PORT_BIT    7
`define TCWR_B5_PUMP_HI  6
`define TCWR_B5_PUMP_LO  5
`define TCWR_B5_REF_HI   4
`define TCWR_B6_RSW      3
`define TCWR_B7_BW_HI    6
`define TCWR_B7_BW_LO    1
`define TCWR_B13_PD      7
`define TCWR_B13_FR_HI   6
`define TCWR_B13_FR_LO   2
`define TCWR_B13_CLR     1
`define TCWR_B13_TL      0
`define TCWR_B2_RATIO_HI 6
`define TCWR_B5_BASE_HI  2
`define TCWR_B5_MUL_LO   3
`define TCWR_RST_RATIO   9'h002
`define TCWR_RST_BW      6'h10
`define TCWR_RST_FREF    5'h0a
`endif

// file: hw/tcwr_bank.v
// Purpose: Write-only control register bank of a satellite tuner
// Assumes: A bus front end delivers whole acknowledged data bytes,
//          with a start pulse per write transfer
// Notes:   Outputs drive the analogue sections
//
// Overview of operation
// - Tuning ratio output is the 15-bit division word
// - Bit 5 of byte 4 boosts RF gain
// - Byte 4 bits 4:3 set prefilter gain
// - Byte 4 bits 2:1 set postfilter gain
// - Byte 4 bit 0 disables RF bypass
// - Port bits pull pins low when set
// - Power down bit or sleep pin shut analogue
// - Power down never alters register contents
// - Logic reset bit resets, then clears itself
// - Writing zero to reset bit does nothing
// - Logic reset restores bytes 7, 9-13 only
// - Pump current code 11 is never programmed; the bank does not block it, and byte 5 bits 6:5 pass through unchecked
// - Reference divider decodes base times multiplier
// - Resistor switch bit freezes chosen resistor
// - Bandwidth code 63 is never written; the bank does not block it, and byte 7 bits 6:1 pass through unchecked
// - LO test bit enables LO monitor pin
// - Comparison rate is crystal over reference ratio
// - First byte's leading bits select even byte pair
// - Bytes after the last register are ignored
`include "tcwr_defs.vh"
module tcwr_bank
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // Byte stream from the bus front end
  input  wire        xfer_start_i,
  input  wire        byte_valid_i,
  input  wire [7:0]  byte_data_i,
  // Hardware sleep pin, active high
  input  wire        sleep_i,
  // Synthesizer controls
  output reg  [14:0] synth_divide_ratio_o,
  output reg  [8:0]  pll_ref_ratio_o,
  output reg         pll_ref_illegal_o,
  output reg  [1:0]  pump_current_sel_o,
  // Gain and bypass
  output reg         rf_gain_boost_o,
  output reg  [1:0]  prefilter_gain_o,
  output reg  [1:0]  postfilter_gain_o,
  output reg         bypass_disable_o,
  // Filter controls
  output reg         resistor_switch_freeze_o,
  output reg  [5:0]  filter_bw_code_o,
  output reg  [4:0]  filter_ref_divider_o,
  // Power and test
  output reg         power_down_request_o,
  output reg         analog_shutdown_o,
  output reg         lo_monitor_enable_o,
  output reg         logic_reset_pulse_o,
  // Raw control data bytes 8 to 12
  output reg  [39:0] control_data_o,
  // Open-drain ports, enable low while driving low
  output wire        port_a_drive_o,
  output wire        port_a_oe_n_o,
  output wire        port_b_drive_o,
  output wire        port_b_oe_n_o
);

  // Register array, index is byte number
  reg [7:0] regs_reg [2:13];
  reg [7:0] regs_next [2:13];
  reg [3:0] ptr_reg;
  reg [3:0] ptr_next;
  reg       first_reg;
  reg       first_next;
  integer   i;
  integer   j;

  // Byte selected by the leading bits of the first data byte
  function [3:0] start_byte;
    input [7:0] d;
    begin
      if (!d[7])
        start_byte = 4'h2;
      else if (!d[6])
        start_byte = 4'h4;
      else
        start_byte = {1'b0, d[5:4], 1'b0} + 4'h6;
    end
  endfunction

  // Reset value of a byte
  function [7:0] rst_val;
    input [3:0] n;
    begin
      case (n)
        4'h2: rst_val = `TCWR_RST_B2;
        4'h3: rst_val = `TCWR_RST_B3;
        4'h4: rst_val = `TCWR_RST_B4;
        4'h5: rst_val = `TCWR_RST_B5;
        4'h6: rst_val = `TCWR_RST_B6;
        4'h7: rst_val = `TCWR_RST_B7;
        4'h8: rst_val = `TCWR_RST_B8;
        4'h9: rst_val = `TCWR_RST_B9;
        4'ha: rst_val = `TCWR_RST_B10;
        4'hb: rst_val = `TCWR_RST_B11;
        4'hc: rst_val = `TCWR_RST_B12;
        4'hd: rst_val = `TCWR_RST_B13;
        default: rst_val = 8'h00;
      endcase
    end
  endfunction

  // Bytes restored by the control logic reset
  function clr_hit;
    input [3:0] n;
    begin
      clr_hit = (n == 4'h7) || (n >= 4'h9 && n <= `TCWR_LAST_BYTE);
    end
  endfunction

  // Reference divide ratio: power-of-two base times 1, 1.25, 1.5, 1.75
  function [8:0] ref_ratio;
    input [4:0] r;
    reg   [8:0] base;
    begin
      base = 9'h002 << r[2:0];
      if (r[2:0] == 3'h0)
        ref_ratio = 9'h002;
      else
        ref_ratio = base + ((base >> 2) * {7'h00, r[4:3]});
    end
  endfunction

  // Write sequencing with pair addressing
  always @*
  begin
    ptr_next   = ptr_reg;
    first_next = first_reg;
    for (i = 2; i <= 13; i = i + 1)
      regs_next[i] = regs_reg[i];
    if (xfer_start_i)
    begin
      first_next = 1'b1;
    end
    else if (byte_valid_i)
    begin
      if (first_reg)
      begin
        regs_next[start_byte(byte_data_i)] = byte_data_i;
        ptr_next   = start_byte(byte_data_i) + 4'h1;
        first_next = 1'b0;
      end
      else if (ptr_reg <= `TCWR_LAST_BYTE && ptr_reg >= `TCWR_FIRST_BYTE)
      begin
        regs_next[ptr_reg] = byte_data_i;
        ptr_next = ptr_reg + 4'h1;
      end
      else
      begin
        ptr_next = 4'hf;
      end
    end
    // Logic reset: one-cycle pulse restores selected bytes, clearing itself
    if (regs_reg[13][`TCWR_B13_CLR])
    begin
      for (i = 2; i <= 13; i = i + 1)
        if (clr_hit(i[3:0]))
          regs_next[i] = rst_val(i[3:0]);
    end
  end

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      regs_reg[2]  <= `TCWR_RST_B2;
      regs_reg[3]  <= `TCWR_RST_B3;
      regs_reg[4]  <= `TCWR_RST_B4;
      regs_reg[5]  <= `TCWR_RST_B5;
      regs_reg[6]  <= `TCWR_RST_B6;
      regs_reg[7]  <= `TCWR_RST_B7;
      regs_reg[8]  <= `TCWR_RST_B8;
      regs_reg[9]  <= `TCWR_RST_B9;
      regs_reg[10] <= `TCWR_RST_B10;
      regs_reg[11] <= `TCWR_RST_B11;
      regs_reg[12] <= `TCWR_RST_B12;
      regs_reg[13] <= `TCWR_RST_B13;
      ptr_reg      <= 4'hf;
      first_reg    <= 1'b0;
    end
    else
    begin
      for (j = 2; j <= 13; j = j + 1)
        regs_reg[j] <= regs_next[j];
      ptr_reg   <= ptr_next;
      first_reg <= first_next;
    end
  end

  // Synthesizer fields, registered
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      synth_divide_ratio_o <= 15'h0000;
      pll_ref_ratio_o      <= `TCWR_RST_RATIO;
      pll_ref_illegal_o    <= 1'b0;
      pump_current_sel_o   <= 2'h0;
    end
    else
    begin
      synth_divide_ratio_o <= {regs_reg[2][`TCWR_B2_RATIO_HI:0], regs_reg[3]};
      pll_ref_ratio_o      <= ref_ratio(regs_reg[5][`TCWR_B5_REF_HI:0]);
      pll_ref_illegal_o    <= (regs_reg[5][`TCWR_B5_BASE_HI:0] == 3'h0) &&
                              (regs_reg[5][`TCWR_B5_REF_HI:`TCWR_B5_MUL_LO] != 2'h0);
      pump_current_sel_o   <= regs_reg[5][`TCWR_B5_PUMP_HI:`TCWR_B5_PUMP_LO];
    end
  end

  // Gain and bypass fields, registered
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rf_gain_boost_o   <= 1'b0;
      prefilter_gain_o  <= 2'h0;
      postfilter_gain_o <= 2'h0;
      bypass_disable_o  <= 1'b0;
    end
    else
    begin
      rf_gain_boost_o   <= regs_reg[4][`TCWR_B4_RFG];
      prefilter_gain_o  <= regs_reg[4][`TCWR_B4_PRE_HI:`TCWR_B4_PRE_LO];
      postfilter_gain_o <= regs_reg[4][`TCWR_B4_POST_HI:`TCWR_B4_POST_LO];
      bypass_disable_o  <= regs_reg[4][`TCWR_B4_BYP];
    end
  end

  // Filter fields, registered
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      resistor_switch_freeze_o <= 1'b0;
      filter_bw_code_o         <= `TCWR_RST_BW;
      filter_ref_divider_o     <= `TCWR_RST_FREF;
    end
    else
    begin
      resistor_switch_freeze_o <= regs_reg[6][`TCWR_B6_RSW];
      filter_bw_code_o         <= regs_reg[7][`TCWR_B7_BW_HI:`TCWR_B7_BW_LO];
      filter_ref_divider_o     <= regs_reg[13][`TCWR_B13_FR_HI:`TCWR_B13_FR_LO];
    end
  end

  // Power and test fields, registered
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      power_down_request_o <= 1'b0;
      analog_shutdown_o    <= 1'b0;
      lo_monitor_enable_o  <= 1'b0;
      logic_reset_pulse_o  <= 1'b0;
    end
    else
    begin
      power_down_request_o <= regs_reg[13][`TCWR_B13_PD];
      analog_shutdown_o    <= regs_reg[13][`TCWR_B13_PD] | sleep_i;
      lo_monitor_enable_o  <= regs_reg[13][`TCWR_B13_TL];
      logic_reset_pulse_o  <= regs_reg[13][`TCWR_B13_CLR];
    end
  end

  // Raw control data bytes, registered, reset matches the bytes
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      control_data_o <= {`TCWR_RST_B8, `TCWR_RST_B9, `TCWR_RST_B10,
                         `TCWR_RST_B11, `TCWR_RST_B12};
    end
    else
    begin
      control_data_o <= {regs_reg[8], regs_reg[9], regs_reg[10],
                         regs_reg[11], regs_reg[12]};
    end
  end

  // Open-drain ports: driven low only when the bit is set
  assign port_a_drive_o = 1'b0;
  assign port_a_oe_n_o  = ~regs_reg[5][`TCWR_PORT_BIT];
  assign port_b_drive_o = 1'b0;
  assign port_b_oe_n_o  = ~regs_reg[7][`TCWR_PORT_BIT];

endmodule

// file: verification/tcwr_bank_properties.sv
// Purpose: Assertions on tcwr_bank ports
// Assumes: One clock domain
// Notes:   Bound below
module tcwr_bank_properties
(
  // Clock, reset and inputs
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        byte_valid_i,
  input wire logic        sleep_i,
  // Outputs
  input wire logic [8:0]  pll_ref_ratio_o,
  input wire logic        pll_ref_illegal_o,
  input wire logic [5:0]  filter_bw_code_o,
  input wire logic [39:0] control_data_o,
  input wire logic        power_down_request_o,
  input wire logic        analog_shutdown_o,
  input wire logic        logic_reset_pulse_o,
  input wire logic        port_a_drive_o,
  input wire logic        port_b_drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_quiet;
    !byte_valid_i [*4];
  endsequence
  sequence s_clr;
    logic_reset_pulse_o;
  endsequence
  property p_hold;
    s_quiet |-> $stable({filter_bw_code_o, control_data_o});
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_sleep;
    sleep_i |=> analog_shutdown_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep");
  property p_pd;
    power_down_request_o |-> analog_shutdown_o;
  endproperty
  a_pd: assert property (p_pd) else $error("pd");
  property p_once;
    s_clr |=> !logic_reset_pulse_o;
  endproperty
  a_once: assert property (p_once) else $error("once");
  property p_clr;
    s_clr |-> ##[0:1] (control_data_o[31:0] == 32'h30e175f0 && filter_bw_code_o == 6'h10);
  endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_port;
    !port_a_drive_o && !port_b_drive_o;
  endproperty
  a_port: assert property (p_port) else $error("port");
  property p_bw;
    filter_bw_code_o != 6'h3f;
  endproperty
  a_bw: assert property (p_bw) else $error("bw");
  property p_ratio;
    !pll_ref_illegal_o |-> pll_ref_ratio_o inside {[9'h2:9'h1c0]};
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio");
endmodule
bind tcwr_bank tcwr_bank_properties u_chk (.*);

// file: verification/tcwr_host.sv
// Purpose: Host model for tcwr_bank
// Assumes: Drives on falling edges
// Notes:   Data is scrambled when idle
module tcwr_host
(
  // Clock
  input  wire logic  clk_i,
  // Byte stream
  output logic       start_o,
  output logic       valid_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {start_o, valid_o, data_o} = 10'h0;
  task drv(input logic s, input logic v, input logic [7:0] d);
    @(negedge clk_i);
    start_o = s;
    valid_o = v;
    data_o = d;
  endtask
  task wp(input logic [7:0] a, input logic [7:0] b);
    drv(1'b1, 1'b0, ~data_o);
    drv(1'b0, 1'b1, a);
    drv(1'b0, 1'b1, b);
    drv(1'b0, 1'b0, ~b);
  endtask
  task init;
    logic [55:0] s;
    s = 56'hd340e35bf045ff;
    wp(8'h12, 8'h34);
    wp(8'hab, 8'hc9);
    wp(8'hc0, 8'ha4);
    wp(8'hc8, 8'ha4);
    drv(1'b1, 1'b0, 8'h00);
    for (int i = 6; i >= 0; i--)
      drv(1'b0, 1'b1, s[i*8+:8]);
    wp(8'he3, 8'hf9);
  endtask
endmodule

// file: verification/tcwr_bank_tb.sv
// Purpose: Self-checking bench for tcwr_bank
// Assumes: Host model drives the byte stream
// Notes:   Checks at falling edges
module tcwr_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        sleep_i = 1'b0;
  wire         st, vl, il, rg, bp, fz, pd, sd, lo, pl, ao, bo;
  wire [7:0]   d;
  wire [14:0]  sy;
  wire [8:0]   ra;
  wire [1:0]   pu, pr, po;
  wire [5:0]   bw;
  wire [4:0]   fr;
  wire [39:0]  cd;
  integer      miscompares = 0;
  integer      tests_run = 0;
  integer      k;
  always #12.5 clk_i = ~clk_i;
  tcwr_host h (.clk_i(clk_i), .start_o(st), .valid_o(vl), .data_o(d));
  tcwr_bank DUT (.clk_i(clk_i), .nrst_i(nrst_i), .xfer_start_i(st), .byte_valid_i(vl),
    .byte_data_i(d), .sleep_i(sleep_i), .synth_divide_ratio_o(sy), .pll_ref_ratio_o(ra),
    .pll_ref_illegal_o(il), .pump_current_sel_o(pu), .rf_gain_boost_o(rg),
    .prefilter_gain_o(pr), .postfilter_gain_o(po), .bypass_disable_o(bp),
    .resistor_switch_freeze_o(fz), .filter_bw_code_o(bw), .filter_ref_divider_o(fr),
    .power_down_request_o(pd), .analog_shutdown_o(sd), .lo_monitor_enable_o(lo),
    .logic_reset_pulse_o(pl), .control_data_o(cd), .port_a_drive_o(), .port_a_oe_n_o(ao),
    .port_b_drive_o(), .port_b_oe_n_o(bo));
  task chk(input string n, input logic [39:0] e, input logic [39:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task give_verdict;
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task settle;
    repeat (2) @(negedge clk_i);
  endtask
  initial
  begin
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    settle;
    chk("cd", 40'hdb30e175f0, cd);
    chk("gain", 8'h01, {rg, pr, po, bp, ao});
    h.init;
    settle;
    chk("synth", 15'h1234, sy);
    chk("gain", 8'h56, {rg, pr, po, bp, ao});
    chk("pump", 11'h405, {pu, ra});
    chk("bw", 8'h52, {bo, fz, bw});
    chk("cd", 40'hd340e3f9f0, cd);
    chk("b13", 7'h23, {pd, fr, lo});
    sleep_i = 1'b1;
    settle;
    chk("sleep", 2'h1, {pd, sd});
    chk("cd", 40'hd340e3f9f0, cd);
    sleep_i = 1'b0;
    h.wp(8'hf0, 8'hc5);
    settle;
    chk("pd", 2'h3, {pd, sd});
    h.wp(8'hf0, 8'h47);
    for (k = 0; k < 8 && pl !== 1'b1; k++)
      @(negedge clk_i);
    chk("pulse", 1'b1, pl);
    if (pl !== 1'b1)
      give_verdict;
    settle;
    chk("pulse", 1'b0, pl);
    chk("cd", 40'hd330e175f0, cd);
    chk("b13", 8'h14, {pd, sd, fr, lo});
    chk("keep", 17'h048d1, {sy, ao, fz});
    chk("bw", 7'h50, {bo, bw});
    h.wp(8'hab, 8'h1f);
    settle;
    chk("ratio", 9'h1c0, ra);
    h.wp(8'hab, 8'h08);
    settle;
    chk("illegal", 1'b1, il);
    give_verdict;
  end
endmodule
